/* src/stm_monitor.sv */
// Behaviour
// (RULE1) Any single clock-low phase beyond the timeout limit abandons the transfer.
// (RULE2) Clock high beyond 50 us resets the transaction and treats the bus as idle.
// (RULE3) As slave, the master clocks the bus between 10 and 100 kHz.
// (RULE4) As master with no stretching, the device clocks the bus at 51.2 kHz.
// (RULE5) As slave, total own clock stretching per message stays within 25 ms.
// (RULE6) The master's total clock stretching per message stays within 10 ms.
// (RULE7) Bus-off ends when either line rises; traffic is accepted again within 1 ms.
// (RULE8) Timeout or idle reset releases lines, drops partial byte, awaits new start.
`include "stm_regs.svh"

module stm_monitor #(
    parameter int unsigned TIMEOUT_CYC = `STM_CLK_HZ / 1000000 * `STM_TIMEOUT_US,
    parameter int unsigned IDLE_CYC    = `STM_CLK_HZ / 1000000 * `STM_IDLE_US,
    parameter int unsigned SEXT_CYC    = `STM_CLK_HZ / 1000000 * `STM_SEXT_US
) (
    input  wire logic        I_CLOCK,
    input  wire logic        I_ARST_N,
    input  wire logic        I_LINK_CLOCK,
    input  wire logic        I_SCL_IN,
    input  wire logic        I_SDA_IN,
    input  wire logic        I_MASTER_EN,
    input  wire logic        I_STRETCH_REQ,
    input  wire logic        I_SDA_LOW,
    input  wire logic [31:0] I_BUSOFF_LIMIT,
    output logic             O_SCL_OUT,
    output logic             O_SCL_OE,
    output logic             O_SDA_OUT,
    output logic             O_SDA_OE,
    output logic             O_IN_MESSAGE,
    output logic             O_TIMEOUT,
    output logic             O_IDLE_RESET,
    output logic             O_BUS_OFF,
    output logic             O_STRETCH_EXPIRED,
    output logic [7:0]       O_RX_BYTE,
    output logic             O_RX_VALID
);

    localparam int unsigned MCLK_HALF =
        $rtoi(`STM_CLK_HZ / (2.0 * `STM_MAS_KHZ * 1000.0));

    // ****************************************************************
    // System domain: pin and event synchronisers
    // ****************************************************************
    stm_pkg::stm_pins_s pin_meta_reg;
    stm_pkg::stm_pins_s pin_sync_reg;
    logic [1:0]         evt_meta_reg;
    logic [1:0]         evt_sync_reg;
    logic [1:0]         evt_prev_reg;
    logic [1:0]         evt_tgl_reg;
    logic               start_evt;
    logic               stop_evt;

    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pin_meta_reg <= '{scl: 1'b1, sda: 1'b1};
            pin_sync_reg <= '{scl: 1'b1, sda: 1'b1};
            evt_meta_reg <= 2'h0;
            evt_sync_reg <= 2'h0;
            evt_prev_reg <= 2'h0;
        end else begin
            pin_meta_reg <= '{scl: I_SCL_IN, sda: I_SDA_IN};
            pin_sync_reg <= pin_meta_reg;
            evt_meta_reg <= evt_tgl_reg;
            evt_sync_reg <= evt_meta_reg;
            evt_prev_reg <= evt_sync_reg;
        end
    end

    assign start_evt = evt_sync_reg[0] ^ evt_prev_reg[0];
    assign stop_evt  = evt_sync_reg[1] ^ evt_prev_reg[1];

    // ****************************************************************
    // System domain: supervision state
    // ****************************************************************
    stm_pkg::stm_state_e state_reg, state_next;
    stm_pkg::stm_mclk_e  mc_phase_reg, mc_phase_next;
    logic [31:0]         low_cnt_reg, low_cnt_next;
    logic [31:0]         high_cnt_reg, high_cnt_next;
    logic [31:0]         both_cnt_reg, both_cnt_next;
    logic [31:0]         acc_reg, acc_next;
    logic [31:0]         mc_cnt_reg, mc_cnt_next;
    logic                exp_reg, exp_next;
    logic                to_reg, to_next;
    logic                idle_reg, idle_next;
    logic                abort_tgl_reg, abort_tgl_next;
    logic                scl_oe_reg, scl_oe_next;
    logic                sda_oe_reg, sda_oe_next;
    logic                abort;
    logic                hold;

    always_comb begin
        state_next     = state_reg;
        mc_phase_next  = mc_phase_reg;
        mc_cnt_next    = mc_cnt_reg;
        acc_next       = acc_reg;
        exp_next       = exp_reg;
        to_next        = 1'b0;
        idle_next      = 1'b0;
        abort          = 1'b0;
        low_cnt_next   = pin_sync_reg.scl ? 32'h0 : low_cnt_reg + {31'h0, ~&low_cnt_reg};
        high_cnt_next  = !pin_sync_reg.scl ? 32'h0 : high_cnt_reg + {31'h0, ~&high_cnt_reg};
        both_cnt_next  = (pin_sync_reg.scl || pin_sync_reg.sda) ? 32'h0 :
                         both_cnt_reg + {31'h0, ~&both_cnt_reg};
        case (state_reg)
            stm_pkg::ST_IDLE: begin
                if (start_evt) begin
                    state_next    = stm_pkg::ST_ACTIVE;
                    acc_next      = 32'h0;
                    exp_next      = 1'b0;
                    // Idle time before the start is not part of the message
                    high_cnt_next = 32'h0;                              // see (RULE2)
                end
            end
            stm_pkg::ST_ACTIVE: begin
                if (!pin_sync_reg.scl && low_cnt_reg >= TIMEOUT_CYC - 1) begin
                    to_next = 1'b1;                                     // see (RULE1)
                    abort   = 1'b1;
                end else if (pin_sync_reg.scl && high_cnt_reg >= IDLE_CYC - 1) begin
                    idle_next = 1'b1;                                   // see (RULE2)
                    abort     = 1'b1;
                end else if (stop_evt) begin
                    state_next = stm_pkg::ST_IDLE;
                end
            end
            stm_pkg::ST_BUS_OFF: begin
                if (pin_sync_reg.scl || pin_sync_reg.sda) begin
                    state_next = stm_pkg::ST_IDLE;                      // see (RULE7)
                end
            end
            default: begin
                state_next = stm_pkg::ST_IDLE;
            end
        endcase
        if (abort) begin
            state_next = stm_pkg::ST_IDLE;                              // see (RULE8)
        end
        if (state_reg != stm_pkg::ST_BUS_OFF && I_BUSOFF_LIMIT != 32'h0 &&
            !pin_sync_reg.scl && !pin_sync_reg.sda &&
            both_cnt_reg >= I_BUSOFF_LIMIT - 32'h1) begin
            state_next = stm_pkg::ST_BUS_OFF;                           // see (RULE7)
            abort      = 1'b1;
        end
        abort_tgl_next = abort_tgl_reg ^ abort;

        // Own stretching only while the line is already low, capped per message
        hold = I_STRETCH_REQ && !I_MASTER_EN && state_reg == stm_pkg::ST_ACTIVE &&
               acc_reg < SEXT_CYC && (scl_oe_reg || !pin_sync_reg.scl);  // see (RULE5)
        if (scl_oe_reg && !I_MASTER_EN) begin
            acc_next = acc_reg + 32'h1;
        end
        // Stale budget of the last message must not survive the next start
        if (acc_reg >= SEXT_CYC && state_reg == stm_pkg::ST_ACTIVE) begin
            exp_next = 1'b1;                                            // see (RULE5)
        end

        // Master clock; high phase waits while a slave holds the line low
        if (I_MASTER_EN && state_reg != stm_pkg::ST_BUS_OFF) begin
            case (mc_phase_reg)
                stm_pkg::MC_LOW: begin
                    if (mc_cnt_reg >= MCLK_HALF - 1) begin
                        mc_phase_next = stm_pkg::MC_HIGH;               // see (RULE4)
                        mc_cnt_next   = 32'h0;
                    end else begin
                        mc_cnt_next = mc_cnt_reg + 32'h1;
                    end
                end
                stm_pkg::MC_HIGH: begin
                    if (mc_cnt_reg >= MCLK_HALF - 1) begin
                        mc_phase_next = stm_pkg::MC_LOW;                // see (RULE4)
                        mc_cnt_next   = 32'h0;
                    end else if (pin_sync_reg.scl) begin
                        mc_cnt_next = mc_cnt_reg + 32'h1;
                    end
                end
                default: begin
                    mc_phase_next = stm_pkg::MC_HIGH;
                end
            endcase
        end else begin
            mc_phase_next = stm_pkg::MC_HIGH;
            mc_cnt_next   = 32'h0;
        end
        if (abort) begin
            mc_phase_next = stm_pkg::MC_HIGH;
            mc_cnt_next   = 32'h0;
        end

        scl_oe_next = (mc_phase_next == stm_pkg::MC_LOW || hold) && !abort;    // see (RULE8)
        sda_oe_next = I_SDA_LOW && !abort && state_next != stm_pkg::ST_BUS_OFF &&
                      (state_reg == stm_pkg::ST_ACTIVE || I_MASTER_EN);         // see (RULE8)
    end

    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            state_reg     <= stm_pkg::ST_IDLE;
            mc_phase_reg  <= stm_pkg::MC_HIGH;
            low_cnt_reg   <= 32'h0;
            high_cnt_reg  <= 32'h0;
            both_cnt_reg  <= 32'h0;
            acc_reg       <= 32'h0;
            mc_cnt_reg    <= 32'h0;
            exp_reg       <= 1'b0;
            to_reg        <= 1'b0;
            idle_reg      <= 1'b0;
            abort_tgl_reg <= 1'b0;
            scl_oe_reg    <= 1'b0;
            sda_oe_reg    <= 1'b0;
        end else begin
            state_reg     <= state_next;
            mc_phase_reg  <= mc_phase_next;
            low_cnt_reg   <= low_cnt_next;
            high_cnt_reg  <= high_cnt_next;
            both_cnt_reg  <= both_cnt_next;
            acc_reg       <= acc_next;
            mc_cnt_reg    <= mc_cnt_next;
            exp_reg       <= exp_next;
            to_reg        <= to_next;
            idle_reg      <= idle_next;
            abort_tgl_reg <= abort_tgl_next;
            scl_oe_reg    <= scl_oe_next;
            sda_oe_reg    <= sda_oe_next;
        end
    end

    // ****************************************************************
    // Link domain: start/stop detection and byte capture
    // ****************************************************************
    stm_pkg::stm_pins_s lpin_meta_reg;
    stm_pkg::stm_pins_s lpin_sync_reg;
    stm_pkg::stm_pins_s lpin_prev_reg;
    logic               lab_meta_reg, lab_sync_reg, lab_prev_reg;
    logic [1:0]         evt_tgl_next;
    logic [3:0]         bit_cnt_reg, bit_cnt_next;
    logic [7:0]         shift_reg, shift_next;
    logic [7:0]         rx_byte_reg, rx_byte_next;
    logic               rx_valid_reg, rx_valid_next;
    logic               armed_reg, armed_next;
    logic               l_start, l_stop, l_rise, l_abort;

    always_comb begin
        l_start = lpin_prev_reg.scl && lpin_sync_reg.scl && lpin_prev_reg.sda && !lpin_sync_reg.sda;
        l_stop  = lpin_prev_reg.scl && lpin_sync_reg.scl && !lpin_prev_reg.sda && lpin_sync_reg.sda;
        l_rise  = !lpin_prev_reg.scl && lpin_sync_reg.scl;
        l_abort = lab_sync_reg ^ lab_prev_reg;
        evt_tgl_next  = evt_tgl_reg ^ {l_stop, l_start};
        bit_cnt_next  = bit_cnt_reg;
        shift_next    = shift_reg;
        rx_byte_next  = rx_byte_reg;
        rx_valid_next = 1'b0;
        armed_next    = armed_reg;
        if (l_abort || l_stop) begin
            armed_next   = 1'b0;                                        // see (RULE8)
            bit_cnt_next = 4'h0;
            shift_next   = 8'h0;
        end else if (l_start) begin
            armed_next   = 1'b1;
            bit_cnt_next = 4'h0;
            shift_next   = 8'h0;
        end else if (l_rise && armed_reg) begin
            if (bit_cnt_reg == 4'h8) begin
                bit_cnt_next = 4'h0;
            end else begin
                shift_next   = {shift_reg[6:0], lpin_sync_reg.sda};
                bit_cnt_next = bit_cnt_reg + 4'h1;
                if (bit_cnt_reg == 4'h7) begin
                    rx_byte_next  = {shift_reg[6:0], lpin_sync_reg.sda};
                    rx_valid_next = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge I_LINK_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            lpin_meta_reg <= '{scl: 1'b1, sda: 1'b1};
            lpin_sync_reg <= '{scl: 1'b1, sda: 1'b1};
            lpin_prev_reg <= '{scl: 1'b1, sda: 1'b1};
            lab_meta_reg  <= 1'b0;
            lab_sync_reg  <= 1'b0;
            lab_prev_reg  <= 1'b0;
            evt_tgl_reg   <= 2'h0;
            bit_cnt_reg   <= 4'h0;
            shift_reg     <= 8'h0;
            rx_byte_reg   <= 8'h0;
            rx_valid_reg  <= 1'b0;
            armed_reg     <= 1'b0;
        end else begin
            lpin_meta_reg <= '{scl: I_SCL_IN, sda: I_SDA_IN};
            lpin_sync_reg <= lpin_meta_reg;
            lpin_prev_reg <= lpin_sync_reg;
            lab_meta_reg  <= abort_tgl_reg;
            lab_sync_reg  <= lab_meta_reg;
            lab_prev_reg  <= lab_sync_reg;
            evt_tgl_reg   <= evt_tgl_next;
            bit_cnt_reg   <= bit_cnt_next;
            shift_reg     <= shift_next;
            rx_byte_reg   <= rx_byte_next;
            rx_valid_reg  <= rx_valid_next;
            armed_reg     <= armed_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    logic in_msg_reg, bus_off_reg, zero_reg;

    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            in_msg_reg  <= 1'b0;
            bus_off_reg <= 1'b0;
            zero_reg    <= 1'b0;
        end else begin
            in_msg_reg  <= state_next == stm_pkg::ST_ACTIVE;
            bus_off_reg <= state_next == stm_pkg::ST_BUS_OFF;
            zero_reg    <= 1'b0;
        end
    end

    assign O_SCL_OUT         = zero_reg;
    assign O_SDA_OUT         = zero_reg;
    assign O_SCL_OE          = scl_oe_reg;
    assign O_SDA_OE          = sda_oe_reg;
    assign O_IN_MESSAGE      = in_msg_reg;
    assign O_TIMEOUT         = to_reg;
    assign O_IDLE_RESET      = idle_reg;
    assign O_BUS_OFF         = bus_off_reg;
    assign O_STRETCH_EXPIRED = exp_reg;
    assign O_RX_BYTE         = rx_byte_reg;
    assign O_RX_VALID        = rx_valid_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    timeout_fire_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // see (RULE1)
        (state_reg == stm_pkg::ST_ACTIVE && !pin_sync_reg.scl && low_cnt_reg == TIMEOUT_CYC - 1
         && !(both_cnt_reg >= I_BUSOFF_LIMIT - 32'h1 && I_BUSOFF_LIMIT != 32'h0 && !pin_sync_reg.sda))
        |=> O_TIMEOUT && state_reg == stm_pkg::ST_IDLE)
        else $error("clock low timeout not flagged");
    timeout_cause_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // see (RULE1)
        $rose(O_TIMEOUT) |-> $past(low_cnt_reg) >= TIMEOUT_CYC - 1)
        else $error("timeout flagged early");
    idle_reset_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // see (RULE2)
        O_IDLE_RESET |-> $past(high_cnt_reg) >= IDLE_CYC - 1 && state_reg == stm_pkg::ST_IDLE)
        else $error("idle reset without long clock high");
    mclk_half_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // see (RULE4)
        $fell(mc_phase_reg == stm_pkg::MC_LOW) && !$past(abort)
        && $past(I_MASTER_EN) |-> $past(mc_cnt_reg) == MCLK_HALF - 1)
        else $error("master clock low phase wrong length");
    stretch_cap_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // see (RULE5)
        !I_MASTER_EN && acc_reg > SEXT_CYC |-> !O_SCL_OE)
        else $error("own stretching exceeds cap");
    busoff_exit_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // see (RULE7)
        state_reg == stm_pkg::ST_BUS_OFF && (pin_sync_reg.scl || pin_sync_reg.sda)
        |=> !O_BUS_OFF ##1 state_reg == stm_pkg::ST_IDLE)
        else $error("bus off not left after line rise");
    release_lines_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // see (RULE8)
        (O_TIMEOUT || O_IDLE_RESET) |-> !O_SCL_OE && !O_SDA_OE && !O_IN_MESSAGE)
        else $error("lines held after abort");
    start_arm_a: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // see (RULE8)
        $rose(state_reg == stm_pkg::ST_ACTIVE) |-> $past(start_evt))
        else $error("message entered without start");

    to_seen_c:    cover property (@(posedge I_CLOCK) disable iff (!I_ARST_N) O_TIMEOUT);
    busoff_c:     cover property (@(posedge I_CLOCK) disable iff (!I_ARST_N) $fell(O_BUS_OFF));
    mclk_cycle_c: cover property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
        $rose(mc_phase_reg == stm_pkg::MC_LOW));
    idle_seen_c:  cover property (@(posedge I_CLOCK) disable iff (!I_ARST_N) O_IDLE_RESET);

endmodule

/* src/stm_regs.svh */
`ifndef STM_REGS_SVH
`define STM_REGS_SVH

// ****************************************************************
// Clock rate and bus timing figures
// ****************************************************************
`define STM_CLK_HZ      125000000
`define STM_TIMEOUT_US  25000
`define STM_IDLE_US     50
`define STM_SEXT_US     25000
`define STM_MAS_KHZ     51.2

`endif

/* src/stm_pkg.sv */
package stm_pkg;

    // Sampled bus line levels
    typedef struct packed {
        logic scl;
        logic sda;
    } stm_pins_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACTIVE,
        ST_BUS_OFF
    } stm_state_e;

    typedef enum logic {
        MC_HIGH,
        MC_LOW
    } stm_mclk_e;

endpackage

/* sim/stm_host_model.sv */
// ****************************************************************
// Bus host model: drives clock and data as open-drain pull-downs
// ****************************************************************
module stm_host_model #(
    parameter int HALF = 80
) (
    input  wire logic i_clk,
    input  wire logic i_scl,
    output logic      o_scl_low,
    output logic      o_sda_low
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    task automatic set_lines(input logic scl_low, input logic sda_low);
        @(negedge i_clk);
        o_scl_low = scl_low;
        o_sda_low = sda_low;
    endtask

    // Waits while the device stretches the clock low
    task automatic release_scl;
        int w;
        w = 0;
        o_scl_low = 1'b0;
        while (i_scl !== 1'b1 && w < 4000) begin
            @(negedge i_clk);
            w++;
        end
    endtask

    task automatic send_start;
        @(negedge i_clk);
        o_sda_low = 1'b0;
        release_scl();
        wait_cyc(HALF);
        o_sda_low = 1'b1;
        wait_cyc(HALF);
        o_scl_low = 1'b1;
    endtask

    // Equal low and high halves, scaled rate; host adds no extension
    task automatic send_bit(input logic b);
        o_sda_low = !b;
        wait_cyc(HALF);
        release_scl();
        wait_cyc(HALF);
        o_scl_low = 1'b1;
    endtask

    task automatic send_byte(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            send_bit(d[i]);
        end
        send_bit(1'b1);
    endtask

    task automatic send_stop;
        o_sda_low = 1'b1;
        wait_cyc(HALF);
        release_scl();
        wait_cyc(HALF);
        o_sda_low = 1'b0;
        wait_cyc(HALF);
    endtask
endmodule

/* sim/test_smbus_timeout_monitor.sv */
module test_smbus_timeout_monitor;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TMO = 2000;
    localparam int IDL = 400;
    localparam int SEXT = 600;
    localparam int HALF = 80;

    logic clk, lclk, arst_n, men, sreq, sdl;
    logic [31:0] boff_lim;
    logic scl_oe, scl_o, sda_oe, sda_o, in_msg, tmo, idl, boff, sexp, rxv;
    logic [7:0] rx_byte, seed;
    logic host_scl_low, host_sda_low;
    stm_pkg::stm_pins_s pins;
    int num_errors, n_checks, n, mclk;
    logic [7:0] rx_q[$];
    logic [7:0] exp_q[$];

    assign pins.scl = !(host_scl_low | (scl_oe & !scl_o));
    assign pins.sda = !(host_sda_low | (sda_oe & !sda_o));

    // ****************************************************************
    // Clocks, design and host
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = !clk;
    end
    initial begin
        lclk = 1'b0;
        #7;
        forever #15 lclk = !lclk;
    end

    stm_monitor #(.TIMEOUT_CYC(TMO), .IDLE_CYC(IDL), .SEXT_CYC(SEXT)) dut_u (
        .I_CLOCK(clk), .I_ARST_N(arst_n), .I_LINK_CLOCK(lclk),
        .I_SCL_IN(pins.scl), .I_SDA_IN(pins.sda), .I_MASTER_EN(men),
        .I_STRETCH_REQ(sreq), .I_SDA_LOW(sdl), .I_BUSOFF_LIMIT(boff_lim),
        .O_SCL_OUT(scl_o), .O_SCL_OE(scl_oe), .O_SDA_OUT(sda_o), .O_SDA_OE(sda_oe),
        .O_IN_MESSAGE(in_msg), .O_TIMEOUT(tmo), .O_IDLE_RESET(idl), .O_BUS_OFF(boff),
        .O_STRETCH_EXPIRED(sexp), .O_RX_BYTE(rx_byte), .O_RX_VALID(rxv));

    stm_host_model #(.HALF(HALF)) host_u (
        .i_clk(clk), .i_scl(pins.scl), .o_scl_low(host_scl_low), .o_sda_low(host_sda_low));

    always @(negedge lclk) begin
        if (rxv === 1'b1) rx_q.push_back(rx_byte);
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction

    function automatic logic sel(input int k);
        case (k)
            0: return tmo;
            1: return idl;
            2: return boff;
            default: return scl_oe;
        endcase
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rng(input int v, input int lo, input int hi);
        check(32'(v >= lo && v <= hi), 32'h1);
    endtask

    task automatic measure(input int k, input logic lvl, output int cnt);
        cnt = 0;
        while (sel(k) !== lvl && cnt < 5000) begin
            @(posedge clk);
            #1;
            cnt++;
        end
    endtask

    task automatic message(input logic [7:0] d);
        host_u.send_start();
        host_u.send_byte(d);
        exp_q.push_back(d);
        check(in_msg, 1'b1);
        check(sexp, 1'b0);
        host_u.send_stop();
        host_u.wait_cyc(20);
        check(rx_q.size(), exp_q.size());
        check(rx_q[rx_q.size() - 1], d);
    endtask

    task automatic complete_run;
        $display("Checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #400us;
        num_errors++;
        complete_run();
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        arst_n = 1'b0;
        men = 1'b0;
        sreq = 1'b0;
        boff_lim = 32'h0;
        sdl = 1'b0;
        seed = 8'h16;
        num_errors = 0;
        n_checks = 0;
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        repeat (6) @(negedge clk);
        check({scl_oe, sda_oe, boff, in_msg, scl_o, sda_o}, 6'h0);
        message(8'hFF);
        message(8'h00);
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            message(seed);
        end
        // Partial byte with data held low by the device, then clock-low timeout
        host_u.send_start();
        @(negedge clk);
        sdl = 1'b1;
        for (int i = 0; i < 4; i++) host_u.send_bit(seed[i]);
        check(sda_oe, 1'b1);
        measure(0, 1'b1, n);
        rng(n, TMO, TMO + 10);
        check({in_msg, scl_oe, sda_oe}, 3'h0);
        @(negedge clk);
        sdl = 1'b0;
        host_u.set_lines(1'b1, 1'b0);
        for (int i = 0; i < 4; i++) host_u.send_bit(1'b0);
        host_u.set_lines(1'b0, 1'b0);
        host_u.wait_cyc(20);
        check(rx_q.size(), exp_q.size());
        message(lfsr(seed));
        // Clock high without stop
        host_u.send_start();
        host_u.set_lines(1'b0, 1'b1);
        measure(1, 1'b1, n);
        rng(n, IDL, IDL + 10);
        check(in_msg, 1'b0);
        host_u.set_lines(1'b0, 1'b0);
        // Own clock stretching budget
        host_u.send_start();
        @(negedge clk);
        sreq = 1'b1;
        measure(3, 1'b1, n);
        host_u.set_lines(1'b0, 1'b1);
        measure(3, 1'b0, n);
        rng(n, SEXT - 6, SEXT + 4);
        check(sexp, 1'b1);
        @(negedge clk);
        sreq = 1'b0;
        host_u.set_lines(1'b0, 1'b0);
        host_u.wait_cyc(20);
        // Bus-off entry, exit and recovery
        boff_lim = 32'd100;
        host_u.set_lines(1'b1, 1'b0);
        host_u.set_lines(1'b1, 1'b1);
        measure(2, 1'b1, n);
        rng(n, 100, 108);
        host_u.set_lines(1'b1, 1'b0);
        measure(2, 1'b0, n);
        rng(n, 0, 6);
        host_u.set_lines(1'b0, 1'b0);
        message(8'hA5);
        // Master clock halves
        mclk = 125000000 / (2 * 51200);
        @(negedge clk);
        men = 1'b1;
        measure(3, 1'b1, n);
        measure(3, 1'b0, n);
        rng(n, mclk - 2, mclk + 2);
        measure(3, 1'b1, n);
        rng(n, mclk - 2, mclk + 2);
        @(negedge clk);
        men = 1'b0;
        complete_run();
    end
endmodule
